// ### hw/diag_mux_interconnect_cfg.sv
`timescale 1ns/1ps
`default_nettype none
module diag_mux_interconnect_cfg (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	// Register access from the serial command decoder
	input  wire logic       i_cfg_wr,
	input  wire logic [7:0] i_cfg_wdata,
	output logic      [7:0] o_cfg_rdata,
	// Internal source for digital mux mode
	input  wire logic       i_digital_mux_level,
	// Device pins observed in interconnect mode
	input  wire logic       i_err_pin,
	input  wire logic       i_chip_select_pin,
	input  wire logic       i_serial_in_pin,
	input  wire logic       i_serial_clk_pin,
	// Diagnostic output pin
	output logic            o_diag_out,
	output logic            o_diag_out_oe,
	output logic            o_analog_route,
	// Serial data-out buffer override
	output logic            o_sdo_test_level,
	output logic            o_sdo_test_oe
);

	//------------------------------------------------------------
	// Configuration register
	//------------------------------------------------------------
	diag_cfg_pkg::diag_cfg_t cfg_reg;       // Stored configuration

	// Software write, cleared by reset
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cfg_reg <= diag_cfg_pkg::diag_cfg_t'(diag_cfg_pkg::CFG_RST);
		end else if (i_cfg_wr) begin
			cfg_reg <= diag_cfg_pkg::diag_cfg_t'(i_cfg_wdata);
		end
	end

	// Readback of the stored value
	assign o_cfg_rdata = cfg_reg;

	//------------------------------------------------------------
	// Pin synchronisation
	//------------------------------------------------------------
	diag_cfg_pkg::pin_levels_t pins_raw;    // Raw pin levels
	diag_cfg_pkg::pin_levels_t pins_sync;   // Levels after two flops

	assign pins_raw = '{err_pin:         i_err_pin,
	                    chip_select_pin: i_chip_select_pin,
	                    serial_in_pin:   i_serial_in_pin,
	                    serial_clk_pin:  i_serial_clk_pin};

	level_sync #(
		.W ($bits(diag_cfg_pkg::pin_levels_t))
	) u_pin_sync (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_async   (pins_raw),
		.o_sync    (pins_sync)
	);

	//------------------------------------------------------------
	// Source selection
	//------------------------------------------------------------
	logic interc_level;                     // Pin chosen by select field
	logic diag_level_next;                  // Level for the diagnostic pin

	// Interconnect test pin choice
	always_comb begin
		case (cfg_reg.interconnect_select)
			diag_cfg_pkg::ISEL_ERR:  interc_level = pins_sync.err_pin;
			diag_cfg_pkg::ISEL_CS:   interc_level = pins_sync.chip_select_pin;
			diag_cfg_pkg::ISEL_SDI:  interc_level = pins_sync.serial_in_pin;
			diag_cfg_pkg::ISEL_SCLK: interc_level = pins_sync.serial_clk_pin;
			// No test and unused codes observe nothing
			default:                 interc_level = 1'b0;
		endcase
	end

	// Mode choice
	always_comb begin
		case (cfg_reg.diag_mode_select)
			diag_cfg_pkg::MODE_DIRECT:  diag_level_next = cfg_reg.diag_direct_level;
			diag_cfg_pkg::MODE_DIGITAL: diag_level_next = i_digital_mux_level;
			diag_cfg_pkg::MODE_INTERC:  diag_level_next = interc_level;
			// Analog path drives the pin through its own buffer
			default:                    diag_level_next = 1'b0;
		endcase
	end

	//------------------------------------------------------------
	// Diagnostic pin drivers
	//------------------------------------------------------------
	logic analog_mode;                      // Analog mux selected

	assign analog_mode = (cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_ANALOG);

	// Digital driver enable follows the enable bit outside analog mode
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_diag_out_oe  <= 1'b0;
			o_analog_route <= 1'b0;
		end else begin
			o_diag_out_oe  <= cfg_reg.diag_out_enable & ~analog_mode;
			o_analog_route <= cfg_reg.diag_out_enable & analog_mode;
		end
	end

	// Output level register
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_diag_out <= 1'b0;
		end else begin
			o_diag_out <= diag_level_next;
		end
	end

	//------------------------------------------------------------
	// Serial data-out test override
	//------------------------------------------------------------
	// Active while digital mode is set and chip select is idle high
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_sdo_test_oe    <= 1'b0;
			o_sdo_test_level <= 1'b0;
		end else begin
			o_sdo_test_oe    <= (cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_DIGITAL)
			                    & pins_sync.chip_select_pin;
			o_sdo_test_level <= cfg_reg.dataout_test_level;
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	AST_OE_FOLLOWS_ENABLE: assert property (
		!$past(cfg_reg.diag_out_enable) |-> !o_diag_out_oe && !o_analog_route)
		else $error("diagnostic pin driven while disabled");

	AST_ENABLE_DRIVES: assert property (
		cfg_reg.diag_out_enable && cfg_reg.diag_mode_select != diag_cfg_pkg::MODE_ANALOG
		|=> o_diag_out_oe)
		else $error("diagnostic pin not driven while enabled");

	AST_DIRECT_LEVEL: assert property (
		cfg_reg.diag_out_enable && cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_DIRECT
		|=> o_diag_out_oe && o_diag_out == $past(cfg_reg.diag_direct_level))
		else $error("direct mode level wrong");

	AST_NO_TEST_CODE: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_INTERC
		&& cfg_reg.interconnect_select == diag_cfg_pkg::ISEL_NONE |=> !o_diag_out)
		else $error("no-test code observed a pin");

	AST_ERR_PIN: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_INTERC
		&& cfg_reg.interconnect_select == diag_cfg_pkg::ISEL_ERR
		|=> o_diag_out == $past(i_err_pin, 3))
		else $error("error pin not shown");

	AST_CS_PIN: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_INTERC
		&& cfg_reg.interconnect_select == diag_cfg_pkg::ISEL_CS
		|=> o_diag_out == $past(i_chip_select_pin, 3))
		else $error("chip select pin not shown");

	AST_SCLK_PIN: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_INTERC
		&& cfg_reg.interconnect_select == diag_cfg_pkg::ISEL_SCLK
		|=> o_diag_out == $past(i_serial_clk_pin, 3))
		else $error("serial clock pin not shown");

	AST_SDI_PIN: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_INTERC
		&& cfg_reg.interconnect_select == diag_cfg_pkg::ISEL_SDI
		|=> o_diag_out == $past(i_serial_in_pin, 3))
		else $error("serial data-in pin not shown");

	AST_UNUSED_CODES: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_INTERC
		&& cfg_reg.interconnect_select > diag_cfg_pkg::ISEL_SCLK |=> !o_diag_out)
		else $error("unused select code observed a pin");

	AST_DIGITAL_MODE: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_DIGITAL
		|=> o_diag_out == $past(i_digital_mux_level))
		else $error("digital mux level not routed");

	AST_ANALOG_MODE: assert property (
		cfg_reg.diag_out_enable && cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_ANALOG
		|=> o_analog_route && !o_diag_out_oe)
		else $error("analog route not taken");

	AST_SDO_OVERRIDE: assert property (
		o_sdo_test_oe |-> $past(cfg_reg.diag_mode_select) == diag_cfg_pkg::MODE_DIGITAL
		&& o_sdo_test_level == $past(cfg_reg.dataout_test_level))
		else $error("data-out override wrong");

	AST_SDO_ACTIVE: assert property (
		cfg_reg.diag_mode_select == diag_cfg_pkg::MODE_DIGITAL && pins_sync.chip_select_pin
		|=> o_sdo_test_oe)
		else $error("data-out override not taken");

	AST_SDO_LEVEL: assert property (
		1'b1 |=> o_sdo_test_level == $past(cfg_reg.dataout_test_level))
		else $error("data-out test level does not follow stored bit");

	// Reset is excluded from the default disable so that its effect is seen
	AST_RESET_CLEARS: assert property (
		@(posedge i_clk) disable iff (1'b0)
		i_sys_rst |=> cfg_reg == diag_cfg_pkg::CFG_RST && !o_diag_out && !o_diag_out_oe
		&& !o_analog_route && !o_sdo_test_oe && !o_sdo_test_level)
		else $error("reset did not clear configuration");

endmodule // diag_mux_interconnect_cfg
`default_nettype wire

// ### hw/diag_cfg_pkg.sv
//----------------------------------------------------------------
// Diagnostic output configuration constants and carriers
//----------------------------------------------------------------
package diag_cfg_pkg;

	// Register width and reset value
	localparam int        CFG_W       = 8;
	localparam logic [7:0] CFG_RST     = 8'h00;

	// Field positions inside the configuration register
	localparam int        POS_ENABLE  = 7;
	localparam int        POS_SDO_LVL = 6;
	localparam int        POS_DIRECT  = 5;
	localparam int        POS_ISEL_LO = 2;
	localparam int        POS_MODE_LO = 0;

	// Diagnostic mode codes
	localparam logic [1:0] MODE_DIRECT  = 2'h0;
	localparam logic [1:0] MODE_DIGITAL = 2'h1;
	localparam logic [1:0] MODE_ANALOG  = 2'h2;
	localparam logic [1:0] MODE_INTERC  = 2'h3;

	// Interconnect test select codes
	localparam logic [2:0] ISEL_NONE    = 3'h0;
	localparam logic [2:0] ISEL_ERR     = 3'h1;
	localparam logic [2:0] ISEL_CS      = 3'h2;
	localparam logic [2:0] ISEL_SDI     = 3'h3;
	localparam logic [2:0] ISEL_SCLK    = 3'h4;

	// Configuration register layout, MSB first
	typedef struct packed {
		logic       diag_out_enable;
		logic       dataout_test_level;
		logic       diag_direct_level;
		logic [2:0] interconnect_select;
		logic [1:0] diag_mode_select;
	} diag_cfg_t;

	// Observed pin levels, raw and after synchronisation
	typedef struct packed {
		logic err_pin;
		logic chip_select_pin;
		logic serial_in_pin;
		logic serial_clk_pin;
	} pin_levels_t;

endpackage

// ### hw/level_sync.sv
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------------------------------
// Two-stage synchroniser for asynchronous pin levels
//----------------------------------------------------------------
module level_sync #(
	parameter int W = 4
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_sys_rst,
	// Levels in and out
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);

	// Refuse a width that cannot carry any level
	if (W < 1) begin : gen_bad_width
		$error("level_sync: W must be at least 1");
	end

	logic [W-1:0] meta_reg;   // First stage, read only by second stage

	// Two flip-flops in a row
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_reg <= '0;
			o_sync   <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end

endmodule // level_sync
`default_nettype wire

// ### dv/mcu_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------------------------------
// Controller side pin model
//----------------------------------------------------------------
module mcu_pin_model (
	// Clock
	input  wire logic                      i_clk,
	// Levels requested by the bench
	input  wire diag_cfg_pkg::pin_levels_t i_req,
	// Levels on the device pins
	output wire diag_cfg_pkg::pin_levels_t o_pins
);
	// Held pin levels, idle low at power up
	diag_cfg_pkg::pin_levels_t held_reg = '0;

	// Pins move only after a falling edge, clear of device sampling
	always @(negedge i_clk) begin
		held_reg <= i_req;
	end

	// Drive the pins from the held levels
	assign o_pins = held_reg;
endmodule // mcu_pin_model
`default_nettype wire

// ### dv/test_diag_mux_interconnect_cfg.sv
`timescale 1ns/1ps
`default_nettype none
//----------------------------------------------------------------
// Testbench top
//----------------------------------------------------------------
module test_diag_mux_interconnect_cfg;
	logic                      i_clk = 1'b0;
	logic                      i_sys_rst = 1'b1;
	logic                      i_cfg_wr = 1'b0;
	logic [7:0]                i_cfg_wdata = 8'h00;
	logic                      dig = 1'b0;
	diag_cfg_pkg::pin_levels_t req = '0;
	diag_cfg_pkg::pin_levels_t pins;
	logic [7:0]                rdata;
	logic                      dout, doe, aroute, slvl, soe;
	int                        err_count = 0;
	int                        samples_checked = 0;

	// Clock at 10 MHz
	always #50 i_clk = ~i_clk;

	// Pin partner and device block
	mcu_pin_model mcu_pin_model_i (.i_clk(i_clk), .i_req(req), .o_pins(pins));
	diag_mux_interconnect_cfg diag_mux_interconnect_cfg_i (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_cfg_wr(i_cfg_wr),
		.i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(rdata), .i_digital_mux_level(dig),
		.i_err_pin(pins.err_pin), .i_chip_select_pin(pins.chip_select_pin),
		.i_serial_in_pin(pins.serial_in_pin), .i_serial_clk_pin(pins.serial_clk_pin),
		.o_diag_out(dout), .o_diag_out_oe(doe), .o_analog_route(aroute),
		.o_sdo_test_level(slvl), .o_sdo_test_oe(soe));

	// Expected {sdo oe, sdo level, analog, oe, driven level}
	function automatic logic [4:0] expect_out(diag_cfg_pkg::diag_cfg_t f,
			diag_cfg_pkg::pin_levels_t p, logic d);
		logic lvl;
		logic oe;
		case (f.interconnect_select)
			diag_cfg_pkg::ISEL_ERR:  lvl = p.err_pin;
			diag_cfg_pkg::ISEL_CS:   lvl = p.chip_select_pin;
			diag_cfg_pkg::ISEL_SDI:  lvl = p.serial_in_pin;
			diag_cfg_pkg::ISEL_SCLK: lvl = p.serial_clk_pin;
			default:                 lvl = 1'b0;
		endcase
		if (f.diag_mode_select == diag_cfg_pkg::MODE_DIRECT) lvl = f.diag_direct_level;
		if (f.diag_mode_select == diag_cfg_pkg::MODE_DIGITAL) lvl = d;
		oe = f.diag_out_enable && (f.diag_mode_select != diag_cfg_pkg::MODE_ANALOG);
		return {(f.diag_mode_select == diag_cfg_pkg::MODE_DIGITAL) && p.chip_select_pin,
			f.dataout_test_level,
			f.diag_out_enable && (f.diag_mode_select == diag_cfg_pkg::MODE_ANALOG),
			oe, oe & lvl};
	endfunction

	// Compare and count
	task automatic check(logic [7:0] seen, logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Write one value with fresh pin levels, then compare once settled
	task automatic step(logic [7:0] v);
		logic [7:0] seen_out;
		logic [7:0] exp_out;
		@(negedge i_clk);
		req <= diag_cfg_pkg::pin_levels_t'($urandom);
		dig <= 1'($urandom);
		i_cfg_wr <= 1'b1;
		i_cfg_wdata <= v;
		@(negedge i_clk);
		i_cfg_wr <= 1'b0;
		repeat (4) @(negedge i_clk);
		check(rdata, v);
		seen_out = {3'h0, soe, slvl, aroute, doe, dout & doe};
		exp_out = {3'h0, expect_out(v, req, dig)};
		check(seen_out, exp_out);
	endtask

	// Controller's data-out check: digital mode, chip select held high throughout
	task automatic sdo_check(logic lvl);
		@(negedge i_clk);
		req <= diag_cfg_pkg::pin_levels_t'(4'h4);
		i_cfg_wr <= 1'b1;
		i_cfg_wdata <= {1'b0, lvl, 6'h01};
		@(negedge i_clk);
		i_cfg_wr <= 1'b0;
		repeat (4) @(negedge i_clk);
		check({6'h0, soe, slvl}, {6'h0, 1'b1, lvl});
	endtask

	// Verdict and end of run
	task automatic stop_test;
		if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'hadc9));
		repeat (2) @(negedge i_clk);
		i_sys_rst <= 1'b0;
		check(rdata, 8'h00);
		check({3'h0, dout, slvl, doe, aroute, soe}, 8'h00);
		// Every mode and select code, enabled and disabled
		for (int i = 0; i < 64; i++) begin
			step({i[5], 2'($urandom), i[4:0]});
		end
		// Random configurations
		for (int i = 0; i < 40; i++) begin
			step(8'($urandom));
		end
		// Data-out check with both test levels
		sdo_check(1'b1);
		sdo_check(1'b0);
		// Reset in mid run clears the register
		@(negedge i_clk);
		i_sys_rst <= 1'b1;
		@(negedge i_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_clk);
		check(rdata, 8'h00);
		check({3'h0, dout, slvl, doe, aroute, soe}, 8'h00);
		stop_test;
	end

	// Watchdog against a hang
	initial begin
		#(2000 * 100);
		err_count++;
		stop_test;
	end
endmodule // test_diag_mux_interconnect_cfg
`default_nettype wire
